// ===== logic/dma_addr_pkg.sv
// shared constants for the usb dma address tracking block
package dma_addr_pkg;

   // register bus geometry
   localparam int unsigned AW     = 6;
   localparam int unsigned DW     = 32;

   // register byte offsets, one aligned word each
   localparam logic [5:0]  OFS_CTRL      = 6'h00;
   localparam logic [5:0]  OFS_STATUS    = 6'h04;
   localparam logic [5:0]  OFS_MASK      = 6'h08;
   localparam logic [5:0]  OFS_WR_START  = 6'h10;
   localparam logic [5:0]  OFS_WR_END    = 6'h14;
   localparam logic [5:0]  OFS_WR_EP     = 6'h18;
   localparam logic [5:0]  OFS_WR_BUS    = 6'h1c;
   localparam logic [5:0]  OFS_RD_START  = 6'h20;
   localparam logic [5:0]  OFS_RD_END    = 6'h24;
   localparam logic [5:0]  OFS_RD_BUS    = 6'h28;

   // reset value of every address register
   localparam logic [31:0] ADDR_RESET    = 32'hffffffff;
   localparam logic [31:0] ZERO_WORD     = 32'h00000000;

   // control register bit positions (write one to act)
   localparam int unsigned CTRL_WR_GO    = 0;
   localparam int unsigned CTRL_RD_GO    = 1;
   localparam int unsigned CTRL_ABORT    = 2;

   // status bit positions, write one to clear
   localparam int unsigned ST_WR_DONE    = 0;
   localparam int unsigned ST_RD_DONE    = 1;
   localparam int unsigned ST_ERROR      = 2;
   localparam int unsigned ST_W          = 3;

   // busy flags read back in the control register
   localparam int unsigned BUSY_WR       = 8;
   localparam int unsigned BUSY_RD       = 9;

   // address advance per datum, in bytes
   localparam logic [31:0] WORD_STEP     = 32'h00000004;

endpackage

// ===== logic/progress_if.sv
// link between the register front end and the write progress tracker
`timescale 1ns/1ps
interface progress_if;
   logic        start;       // load both pointers from start_addr
   logic        abort;       // stop, pointers hold their value
   logic [31:0] start_addr;  // first memory address
   logic [31:0] end_addr;    // final memory address
   logic        ep_push;     // datum moved from endpoint into buffer
   logic        bus_done;    // datum delivered to target memory
   logic [31:0] ep_addr;     // endpoint-side progress
   logic [31:0] bus_addr;    // bus-side progress
   logic        active;      // transfer running
   logic        done;        // one-cycle pulse at completion

   modport ctrl  (output start, abort, start_addr, end_addr, ep_push,
                  bus_done,
                  input  ep_addr, bus_addr, active, done);
   modport track (input  start, abort, start_addr, end_addr, ep_push,
                  bus_done,
                  output ep_addr, bus_addr, active, done);
endinterface

// ===== logic/write_tracker.sv
// write direction progress pointers, endpoint side and bus side
`timescale 1ns/1ps
module write_tracker #(
   parameter logic [31:0] STEP = dma_addr_pkg::WORD_STEP
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // control and progress
   progress_if.track prog
);
   import dma_addr_pkg::*;

   // all tracker state
   typedef struct packed {
      logic [31:0] ep_addr;   // endpoint-side pointer
      logic [31:0] bus_addr;  // bus-side pointer
      logic        active;    // transfer running
      logic        done;      // completion pulse
   } trk_t;

   trk_t st_reg;  // registered state
   trk_t st_next; // next state

   // refuse a step the pointers cannot advance by
   localparam bit STEP_BAD = STEP == ZERO_WORD ||
                             (STEP & (STEP - 32'h00000001)) != ZERO_WORD;
   if (STEP_BAD) begin : g_bad_step
      $error("write_tracker: step must be a nonzero power of two");
   end

   // pointer update
   always_comb begin
      st_next      = st_reg;
      st_next.done = 1'b0;
      if (prog.start) begin
         st_next.ep_addr  = prog.start_addr;
         st_next.bus_addr = prog.start_addr;
         st_next.active   = 1'b1;
      end else if (prog.abort) begin
         st_next.active = 1'b0;
      end else if (st_reg.active) begin
         if (prog.ep_push && st_reg.ep_addr < prog.end_addr) begin
            st_next.ep_addr = st_reg.ep_addr + STEP;
         end
         if (prog.bus_done && st_reg.bus_addr < st_reg.ep_addr) begin
            st_next.bus_addr = st_reg.bus_addr + STEP;
         end
         if (st_next.bus_addr >= prog.end_addr) begin
            st_next.active = 1'b0;
            st_next.done   = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{ep_addr: ADDR_RESET, bus_addr: ADDR_RESET,
                     active: 1'b0, done: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign prog.ep_addr  = st_reg.ep_addr;
   assign prog.bus_addr = st_reg.bus_addr;
   assign prog.active   = st_reg.active;
   assign prog.done     = st_reg.done;

   chk_bus_below_ep: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_reg.active |-> st_reg.bus_addr <= st_reg.ep_addr)
      else $error("bus pointer passed endpoint pointer");

   chk_ep_advance: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_reg.active && !prog.start && !prog.abort && prog.ep_push &&
      st_reg.ep_addr < prog.end_addr
      |=> st_reg.ep_addr == $past(st_reg.ep_addr) + STEP)
      else $error("endpoint pointer did not advance by one step");

   chk_bus_advance: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_reg.active && !prog.start && !prog.abort && prog.bus_done &&
      st_reg.bus_addr < st_reg.ep_addr
      |=> st_reg.bus_addr == $past(st_reg.bus_addr) + STEP)
      else $error("bus pointer did not advance by one step");

   chk_start_load: assert property (
      @(posedge clk) disable iff (!rst_n)
      prog.start |=> st_reg.active && st_reg.ep_addr == $past(prog.start_addr)
                     && st_reg.bus_addr == $past(prog.start_addr))
      else $error("start did not load both pointers");

   chk_idle_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      !st_reg.active && !prog.start
      |=> $stable(st_reg.ep_addr) && $stable(st_reg.bus_addr))
      else $error("pointers moved while stopped");
endmodule

// ===== logic/usb_dma_addr.sv
// usb dma address registers with avalon-mm slave and interrupt
//
// How it works
// - write end address register, read and write
// - endpoint-side write progress address readable
// - endpoint pointer steps per datum into buffer
// - progress held readable after timeout or error
// - bus-side write progress address readable
// - bus pointer steps per datum into memory
// - read start address register, read and write
// - write start address register, read and write
// - read end address register, read and write
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module usb_dma_addr #(
   parameter logic [31:0] STEP = dma_addr_pkg::WORD_STEP
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // avalon-mm register slave
   input  wire logic [dma_addr_pkg::AW-1:0]  address,
   input  wire logic                         read,
   input  wire logic                         write,
   input  wire logic [dma_addr_pkg::DW-1:0]  writedata,
   output logic      [dma_addr_pkg::DW-1:0]  readdata,
   output logic                              waitrequest,
   // write direction datapath events
   input  wire logic                         ep_wr_push,
   input  wire logic                         mem_wr_done,
   output logic      [31:0]                  mem_wr_addr,
   output logic                              wr_active,
   // read direction datapath events
   input  wire logic                         mem_rd_done,
   output logic      [31:0]                  mem_rd_addr,
   output logic                              rd_active,
   // timeout or bus error from the transfer engine
   input  wire logic                         xfer_error,
   // interrupt
   output logic                              irq
);
   import dma_addr_pkg::*;

   // all front end state
   typedef struct packed {
      logic [31:0]   wr_start;  // write start address
      logic [31:0]   wr_end;    // write end address
      logic [31:0]   rd_start;  // read start address
      logic [31:0]   rd_end;    // read end address
      logic [31:0]   rd_addr;   // read bus progress
      logic          rd_active; // read transfer running
      logic          wr_go;     // write start pulse to tracker
      logic          abort;     // abort pulse to tracker
      logic [ST_W-1:0] status;  // sticky events
      logic [ST_W-1:0] mask;    // interrupt enables
      logic [31:0]   rdata;     // read data word
      logic          waitreq;   // waitrequest to the master
      logic          irq;       // interrupt level
   } front_t;

   front_t st_reg;  // registered state
   front_t st_next; // next state

   progress_if prog (); // link to write tracker

   logic          req;      // a request is on the bus
   logic          take;     // request answered at this edge
   logic          wr_take;  // write accepted this cycle
   logic [ST_W-1:0] ev;     // events raised this cycle
   logic          rd_done;  // read transfer reached its end

   // read mux, unmapped offsets read as zero
   function automatic logic [31:0] read_word(input logic [AW-1:0] ofs,
                                             input front_t s,
                                             input logic [31:0] ep,
                                             input logic [31:0] bus,
                                             input logic wr_busy);
      logic [31:0] w;
      w = ZERO_WORD;
      if (ofs == OFS_CTRL) begin
         w[BUSY_WR] = wr_busy;
         w[BUSY_RD] = s.rd_active;
      end else if (ofs == OFS_STATUS) begin
         w[ST_W-1:0] = s.status;
      end else if (ofs == OFS_MASK) begin
         w[ST_W-1:0] = s.mask;
      end else if (ofs == OFS_WR_START) begin
         w = s.wr_start;
      end else if (ofs == OFS_WR_END) begin
         w = s.wr_end;
      end else if (ofs == OFS_WR_EP) begin
         w = ep;
      end else if (ofs == OFS_WR_BUS) begin
         w = bus;
      end else if (ofs == OFS_RD_START) begin
         w = s.rd_start;
      end else if (ofs == OFS_RD_END) begin
         w = s.rd_end;
      end else if (ofs == OFS_RD_BUS) begin
         w = s.rd_addr;
      end
      return w;
   endfunction

   // bus handshake: answer one cycle after the request is seen
   assign req     = read | write;
   assign take    = req & ~st_reg.waitreq;
   assign wr_take = write & ~st_reg.waitreq;

   // read direction completion seen this cycle
   assign rd_done = st_reg.rd_active & mem_rd_done &
                    (st_reg.rd_addr < st_reg.rd_end) &
                    (st_reg.rd_addr + STEP >= st_reg.rd_end);

   // events feeding the sticky status bits
   always_comb begin
      ev             = '0;
      ev[ST_WR_DONE] = prog.done;
      ev[ST_RD_DONE] = rd_done;
      ev[ST_ERROR]   = xfer_error;
   end

   // next state of the front end
   always_comb begin
      st_next       = st_reg;
      st_next.wr_go = 1'b0;
      st_next.abort = xfer_error;

      // waitrequest drops for exactly one cycle per request
      if (req && st_reg.waitreq) begin
         st_next.waitreq = 1'b0;
         st_next.rdata   = read_word(address, st_reg, prog.ep_addr,
                                     prog.bus_addr, prog.active);
      end else begin
         st_next.waitreq = 1'b1;
      end

      // register writes, taken at the edge that ends the wait
      if (wr_take) begin
         if (address == OFS_CTRL) begin
            st_next.wr_go = writedata[CTRL_WR_GO];
            if (writedata[CTRL_ABORT]) begin
               st_next.abort = 1'b1;
            end
         end else if (address == OFS_MASK) begin
            st_next.mask = writedata[ST_W-1:0];
         end else if (address == OFS_WR_START) begin
            st_next.wr_start = writedata;
         end else if (address == OFS_WR_END) begin
            st_next.wr_end = writedata;
         end else if (address == OFS_RD_START) begin
            st_next.rd_start = writedata;
         end else if (address == OFS_RD_END) begin
            st_next.rd_end = writedata;
         end
      end

      // read direction pointer
      if (wr_take && address == OFS_CTRL && writedata[CTRL_RD_GO]) begin
         st_next.rd_addr   = st_reg.rd_start;
         st_next.rd_active = 1'b1;
      end else if (st_next.abort) begin
         // stop, pointer kept for software
         st_next.rd_active = 1'b0;
      end else if (st_reg.rd_active && mem_rd_done &&
                   st_reg.rd_addr < st_reg.rd_end) begin
         st_next.rd_addr = st_reg.rd_addr + STEP;
         if (rd_done) begin
            st_next.rd_active = 1'b0;
         end
      end

      // status: write one clears, a new event wins over the clear
      if (wr_take && address == OFS_STATUS) begin
         st_next.status = st_reg.status & ~writedata[ST_W-1:0];
      end
      st_next.status = st_next.status | ev;

      // interrupt level from the next status and mask
      st_next.irq = |(st_next.status & st_next.mask);
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{wr_start: ADDR_RESET, wr_end: ADDR_RESET,
                     rd_start: ADDR_RESET, rd_end: ADDR_RESET,
                     rd_addr: ADDR_RESET, rd_active: 1'b0,
                     wr_go: 1'b0, abort: 1'b0, status: '0, mask: '0,
                     rdata: ZERO_WORD, waitreq: 1'b1, irq: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // drive the tracker from registered controls, endpoint and memory events straight from the pins
   assign prog.start      = st_reg.wr_go;
   assign prog.abort      = st_reg.abort;
   assign prog.start_addr = st_reg.wr_start;
   assign prog.end_addr   = st_reg.wr_end;
   assign prog.ep_push    = ep_wr_push;
   assign prog.bus_done   = mem_wr_done;

   // write direction pointer pair
   write_tracker #(
      .STEP (STEP)
   ) u_track (
      .clk   (clk),
      .rst_n (rst_n),
      .prog  (prog.track)
   );

   // outputs, each from a flip-flop
   assign readdata    = st_reg.rdata;
   assign waitrequest = st_reg.waitreq;
   assign mem_wr_addr = prog.bus_addr;
   assign wr_active   = prog.active;
   assign mem_rd_addr = st_reg.rd_addr;
   assign rd_active   = st_reg.rd_active;
   assign irq         = st_reg.irq;

   chk_wait_answer: assert property (
      @(posedge clk) disable iff (!rst_n)
      req && st_reg.waitreq |=> !st_reg.waitreq ##1 st_reg.waitreq)
      else $error("waitrequest did not drop for exactly one cycle");

   chk_end_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_take && address == OFS_WR_END |=> st_reg.wr_end == $past(writedata))
      else $error("write end address not stored");

   chk_rdstart_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_take && address == OFS_RD_START
      |=> st_reg.rd_start == $past(writedata))
      else $error("read start address not stored");

   chk_ep_readback: assert property (
      @(posedge clk) disable iff (!rst_n)
      read && st_reg.waitreq && address == OFS_WR_EP
      |=> st_reg.rdata == $past(prog.ep_addr))
      else $error("endpoint progress readback wrong");

   chk_rd_start_load: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_take && address == OFS_CTRL && writedata[CTRL_RD_GO]
      |=> rd_active && mem_rd_addr == $past(st_reg.rd_start))
      else $error("read start did not load pointer");

   chk_error_sticky: assert property (
      @(posedge clk) disable iff (!rst_n)
      xfer_error |=> st_reg.status[ST_ERROR] && !rd_active)
      else $error("error event lost or read not stopped");

   chk_status_set: assert property (
      @(posedge clk) disable iff (!rst_n)
      |ev |=> (st_reg.status & $past(ev)) == $past(ev))
      else $error("status event not latched");

   chk_status_w1c: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_take && address == OFS_STATUS
      |=> (st_reg.status & $past(writedata[ST_W-1:0]) & ~$past(ev)) == '0)
      else $error("status bit not cleared by a written one");

   chk_irq_level: assert property (
      @(posedge clk) disable iff (!rst_n)
      irq == |(st_reg.status & st_reg.mask))
      else $error("interrupt level does not follow status and mask");

   chk_wrstart_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_take && address == OFS_WR_START
      |=> st_reg.wr_start == $past(writedata))
      else $error("write start address not stored");

   chk_rdend_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_take && address == OFS_RD_END
      |=> st_reg.rd_end == $past(writedata))
      else $error("read end address not stored");

   chk_bus_readback: assert property (
      @(posedge clk) disable iff (!rst_n)
      read && st_reg.waitreq && address == OFS_WR_BUS
      |=> st_reg.rdata == $past(prog.bus_addr))
      else $error("bus progress readback wrong");

   chk_rd_advance: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_reg.rd_active && mem_rd_done && !xfer_error && !wr_take &&
      st_reg.rd_addr < st_reg.rd_end
      |=> mem_rd_addr == $past(st_reg.rd_addr) + STEP)
      else $error("read pointer did not advance by one step");

   chk_rd_stop_end: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_done && !wr_take |=> !rd_active)
      else $error("read transfer did not stop at its end");

   chk_abort_stops: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_reg.abort && !st_reg.wr_go |=> !wr_active)
      else $error("write transfer ran on after abort");
endmodule

// ===== verification/far_side.sv
// far side model: endpoint fifo, target memory and transfer engine events
`timescale 1ns/1ps
module far_side (
   // clock
   input  wire logic clk,
   // events toward the block
   output logic      ep_wr_push,
   output logic      mem_wr_done,
   output logic      mem_rd_done,
   output logic      xfer_error
);
   // all strobes quiet from time zero
   initial begin
      ep_wr_push  = 1'b0;
      mem_wr_done = 1'b0;
      mem_rd_done = 1'b0;
      xfer_error  = 1'b0;
   end

   // set one strobe, right after a rising edge
   task automatic drive(input int kind, input logic v);
      case (kind)
         1: ep_wr_push  <= v;
         2: mem_wr_done <= v;
         3: xfer_error  <= v;
         default: mem_rd_done <= v;
      endcase
   endtask

   // n one-cycle events, gap idle cycles apart; gap 0 means back to back
   task automatic send(input int kind, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         drive(kind, 1'b1);
         if (gap > 0) begin
            @(posedge clk);
            drive(kind, 1'b0);
            repeat (gap - 1) @(posedge clk);
         end
      end
      @(posedge clk);
      drive(kind, 1'b0);
   endtask
endmodule

// ===== verification/tb_usb_dma_addr.sv
// self-checking bench for the usb dma address registers
`timescale 1ns/1ps
module tb_usb_dma_addr;
   import dma_addr_pkg::*;

   logic        clk, rst_n, read, write, irq, waitrequest;  // bus and core
   logic [5:0]  address;                  // register byte offset
   logic [31:0] writedata, readdata, q;   // bus data
   logic        ep_wr_push, mem_wr_done, mem_rd_done, xfer_error; // events
   logic [31:0] mem_wr_addr, mem_rd_addr; // pointers at the pins
   logic        wr_active, rd_active;     // transfer running flags
   int          errors, tests_run;        // verdict counters
   // read-write and read-only address registers
   logic [5:0]  rw_ofs[4] = '{OFS_WR_START, OFS_WR_END, OFS_RD_START,
                              OFS_RD_END};
   logic [5:0]  ro_ofs[3] = '{OFS_WR_EP, OFS_WR_BUS, OFS_RD_BUS};

   // 10 mhz clock
   always #50 clk = ~clk;

   usb_dma_addr usb_dma_addr_i (.clk(clk), .rst_n(rst_n),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .ep_wr_push(ep_wr_push),
      .mem_wr_done(mem_wr_done), .mem_wr_addr(mem_wr_addr),
      .wr_active(wr_active), .mem_rd_done(mem_rd_done),
      .mem_rd_addr(mem_rd_addr), .rd_active(rd_active),
      .xfer_error(xfer_error), .irq(irq));

   far_side far_side_i (.clk(clk), .ep_wr_push(ep_wr_push),
      .mem_wr_done(mem_wr_done), .mem_rd_done(mem_rd_done),
      .xfer_error(xfer_error));

   // compare and count
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      address   <= a;
      read      <= ~wr;
      write     <= wr;
      writedata <= d;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   // register write
   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   // register read compared with an expected word
   task automatic rd_chk(input string what, input logic [5:0] a,
                         input logic [31:0] exp);
      bus(1'b0, a, ZERO_WORD);
      check(what, q, exp);
   endtask

   // wait the fixed start latency, then look at the flags
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // counts, verdict, end of run
   task automatic final_report();
      $display("tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      final_report();
   end

   initial begin
      clk = 1'b0; rst_n = 1'b0; address = '0; read = 1'b0; write = 1'b0;
      writedata = '0; errors = 0; tests_run = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;

      // reset values of every address register and of the interrupt
      foreach (rw_ofs[i])
         rd_chk("reset rw", rw_ofs[i], ADDR_RESET);
      foreach (ro_ofs[i])
         rd_chk("reset ro", ro_ofs[i], ADDR_RESET);
      rd_chk("reset status", OFS_STATUS, ZERO_WORD);
      rd_chk("reset mask", OFS_MASK, ZERO_WORD);
      check("irq idle", {31'h0, irq}, ZERO_WORD);
      $display("test reset values done");

      // read-write readback, read-only and unmapped places refuse writes
      foreach (rw_ofs[i]) wr_reg(rw_ofs[i], {24'ha5c3e1, 2'h0, rw_ofs[i]});
      foreach (rw_ofs[i])
         rd_chk("rw back", rw_ofs[i],
                {24'ha5c3e1, 2'h0, rw_ofs[i]});
      foreach (ro_ofs[i]) wr_reg(ro_ofs[i], 32'h12345678);
      foreach (ro_ofs[i])
         rd_chk("ro kept", ro_ofs[i], ADDR_RESET);
      wr_reg(6'h3c, 32'h12345678);
      rd_chk("unmapped", 6'h3c, ZERO_WORD);
      $display("test register access done");

      // write transfer of three words, software keeps end above start
      wr_reg(OFS_WR_START, 32'h00000100);
      wr_reg(OFS_WR_END, 32'h0000010c);
      wr_reg(OFS_MASK, ZERO_WORD);
      wr_reg(OFS_CTRL, 32'h00000001);
      settle(3);
      check("wr active", {31'h0, wr_active}, 32'h1);
      rd_chk("busy", OFS_CTRL, 32'h00000100);
      rd_chk("ep start", OFS_WR_EP, 32'h00000100);
      rd_chk("bus start", OFS_WR_BUS, 32'h00000100);
      far_side_i.send(2, 1, 1);
      rd_chk("bus not ahead", OFS_WR_BUS, 32'h00000100);
      far_side_i.send(1, 1, 0);
      rd_chk("ep step", OFS_WR_EP, 32'h00000104);
      far_side_i.send(2, 2, 0);
      rd_chk("bus step", OFS_WR_BUS, 32'h00000104);
      far_side_i.send(1, 3, 2);
      rd_chk("ep at end", OFS_WR_EP, 32'h0000010c);
      check("bus pin", mem_wr_addr, 32'h00000104);
      far_side_i.send(2, 2, 1);
      rd_chk("bus at end", OFS_WR_BUS, 32'h0000010c);
      check("wr stopped", {31'h0, wr_active}, ZERO_WORD);
      rd_chk("wr done", OFS_STATUS, 32'h00000001);
      check("irq masked", {31'h0, irq}, ZERO_WORD);
      wr_reg(OFS_MASK, 32'h00000001);
      rd_chk("mask", OFS_MASK, 32'h00000001);
      check("irq raised", {31'h0, irq}, 32'h1);
      wr_reg(OFS_STATUS, 32'h00000001);
      rd_chk("status clr", OFS_STATUS, ZERO_WORD);
      check("irq cleared", {31'h0, irq}, ZERO_WORD);
      $display("test write transfer done");

      // error in mid transfer leaves both pointers readable
      wr_reg(OFS_WR_START, 32'h00000200);
      wr_reg(OFS_WR_END, 32'h00000220);
      wr_reg(OFS_CTRL, 32'h00000001);
      settle(3);
      far_side_i.send(1, 2, 0);
      far_side_i.send(2, 1, 0);
      far_side_i.send(3, 1, 0);
      far_side_i.send(1, 1, 0);
      rd_chk("ep kept", OFS_WR_EP, 32'h00000208);
      rd_chk("bus kept", OFS_WR_BUS, 32'h00000204);
      check("wr halted", {31'h0, wr_active}, ZERO_WORD);
      rd_chk("err flag", OFS_STATUS, 32'h00000004);
      check("irq err masked", {31'h0, irq}, ZERO_WORD);
      wr_reg(OFS_STATUS, 32'h00000004);
      $display("test error stop done");

      // read transfer from its start address up to the end
      wr_reg(OFS_RD_START, 32'h00000300);
      wr_reg(OFS_RD_END, 32'h00000308);
      wr_reg(OFS_CTRL, 32'h00000002);
      settle(2);
      check("rd active", {31'h0, rd_active}, 32'h1);
      rd_chk("rd start", OFS_RD_BUS, 32'h00000300);
      rd_chk("rd busy", OFS_CTRL, 32'h00000200);
      far_side_i.send(4, 3, 0);
      rd_chk("rd at end", OFS_RD_BUS, 32'h00000308);
      check("rd pin", mem_rd_addr, 32'h00000308);
      check("rd stopped", {31'h0, rd_active}, ZERO_WORD);
      rd_chk("rd done", OFS_STATUS, 32'h00000002);
      $display("test read transfer done");

      // software abort stops both directions, pointers stay readable
      wr_reg(OFS_CTRL, 32'h00000003);
      settle(3);
      far_side_i.send(1, 1, 0);
      far_side_i.send(4, 1, 0);
      wr_reg(OFS_CTRL, 32'h00000004);
      far_side_i.send(1, 1, 0);
      far_side_i.send(4, 1, 0);
      rd_chk("ep after abort", OFS_WR_EP, 32'h00000204);
      rd_chk("bus after abort", OFS_WR_BUS, 32'h00000200);
      rd_chk("rd after abort", OFS_RD_BUS, 32'h00000304);
      rd_chk("idle after abort", OFS_CTRL, ZERO_WORD);
      $display("test abort done");
      final_report();
   end
endmodule
